// file: hw/event_timer_pulse_counter.sv
// 8-bit timer/event counter with preload, prescaler and pulse-width mode
// assumes a cpu register port on mclk; crystal clock arrives as a tick enable
`timescale 1ns/1ps

module event_timer_pulse_counter (
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       count_pin,
   input  wire logic       rtc_tick,
   input  wire logic       opt_rtc_source,
   input  wire logic       opt_rc_rtc_osc,
   input  wire logic       overflow_irq_enable,
   input  wire logic       overflow_flag_clear,
   output logic            overflow_request_flag,
   output logic            irq_request,
   output logic            wake_up,
   output logic            tone_output
);
   import count_timer_pkg::*;

   // ----------------------------------------
   // registers and pin edge detection
   // ----------------------------------------
   logic [7:0] count_ff;
   logic [7:0] nxt_count;
   logic [7:0] preload_ff;
   logic [7:0] nxt_preload;
   logic [7:0] control_ff;
   logic [7:0] nxt_control;
   logic       flag_ff;
   logic       nxt_flag;
   logic       tone_ff;
   logic       nxt_tone;
   logic       pin_prev_ff;
   logic       nxt_pin_prev;
   logic [7:0] psc_ff;
   logic [7:0] nxt_psc;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   pw_state_t  pw_ff;
   pw_state_t  nxt_pw;
   logic       pin_s;
   logic       rise;
   logic       fall;
   logic       act_edge;
   logic       ret_edge;
   logic       src_tick;
   logic       int_tick;
   logic       count_tick;
   logic       overflow;
   logic       wr_count;
   logic       wr_control;
   logic       rd_count;
   logic [2:0] psc_sel;
   logic [1:0] mode;
   logic       count_on;

   pin_sync u_pin_sync (
      .mclk         (mclk),
      .reset        (reset),
      .pin_in       (count_pin),
      .pin_sync_out (pin_s)
   );

   assign psc_sel  = control_ff[psc_hi_pos:psc_lo_pos];
   assign mode     = control_ff[mode_hi_pos:mode_lo_pos];
   assign count_on = control_ff[count_on_pos];
   assign wr_count   = reg_wr && (reg_addr == count_register_addr);
   assign wr_control = reg_wr && (reg_addr == count_control_addr);
   assign rd_count   = reg_rd && (reg_addr == count_register_addr);

   assign rise = pin_s && !pin_prev_ff;
   assign fall = !pin_s && pin_prev_ff;
   // edge_select 0 = rising, 1 = falling
   assign act_edge = control_ff[edge_select_pos] ? fall : rise;
   assign ret_edge = control_ff[edge_select_pos] ? rise : fall;

   // ----------------------------------------
   // internal clock source and prescaler
   // ----------------------------------------
   // crystal ticks only honoured when the rc plus crystal option is fitted
   assign src_tick = (opt_rtc_source && opt_rc_rtc_osc) ? rtc_tick : 1'b1;

   always_comb begin
      nxt_psc = psc_ff;
      if (src_tick)
         nxt_psc = psc_ff + 8'h01;
   end

   // one tick when the low psc_sel+1 bits roll over
   always_comb begin
      int_tick = src_tick && ((psc_ff | ~((8'h02 << psc_sel) - 8'h01)) == 8'hff);
   end

   // ----------------------------------------
   // count tick selection
   // ----------------------------------------
   always_comb begin
      count_tick = 1'b0;
      unique case (mode)
         mode_event:  count_tick = count_on && act_edge;
         mode_timer:  count_tick = count_on && int_tick;
         mode_pulse:  count_tick = (pw_ff == pw_counting) && int_tick;
         mode_unused: count_tick = 1'b0;
      endcase
      // reading blocks the clock so the value is stable; the tick is lost
      if (rd_count)
         count_tick = 1'b0;
   end

   assign overflow = count_tick && (count_ff == count_full);

   // ----------------------------------------
   // pulse-width measurement sequencer
   // ----------------------------------------
   always_comb begin
      nxt_pw = pw_ff;
      if (mode != mode_pulse || !count_on) begin
         nxt_pw = count_on ? pw_armed : pw_idle;
         if (mode == mode_pulse && pw_ff == pw_done && !count_on)
            nxt_pw = pw_done;
      end else begin
         unique case (pw_ff)
            pw_idle:     nxt_pw = pw_armed;
            // only a transition starts it, not the level at arming
            pw_armed:    if (act_edge) nxt_pw = pw_counting;
            pw_counting: if (ret_edge) nxt_pw = pw_done;
            // held until software rewrites count_on
            pw_done:     nxt_pw = pw_done;
         endcase
      end
      // rearm must also be seen while count_on is still low
      if (wr_control && reg_wdata[count_on_pos] && pw_ff == pw_done)
         nxt_pw = pw_armed;
   end

   // ----------------------------------------
   // counter, preload, control, flag
   // ----------------------------------------
   always_comb begin
      nxt_count   = count_ff;
      nxt_preload = preload_ff;
      nxt_control = control_ff;
      if (overflow)
         nxt_count = preload_ff;
      else if (count_tick)
         nxt_count = count_ff + 8'h01;
      if (wr_count) begin
         nxt_preload = reg_wdata;
         if (!count_on)
            nxt_count = reg_wdata;
      end // enabled writes leave the counter alone
      if (wr_control)
         nxt_control = reg_wdata & count_control_wmask;
      // only pulse mode clears count_on itself
      else if (mode == mode_pulse && pw_ff == pw_counting && ret_edge)
         nxt_control[count_on_pos] = 1'b0;
   end

   always_comb begin
      nxt_flag = flag_ff;
      if (overflow_flag_clear)
         nxt_flag = 1'b0;
      // set beats a same-cycle clear
      if (overflow)
         nxt_flag = 1'b1;
   end

   always_comb begin
      nxt_tone     = overflow ? ~tone_ff : tone_ff;
      nxt_pin_prev = pin_s;
      nxt_rdata    = 8'h00;
      if (reg_rd && reg_addr == count_register_addr)
         nxt_rdata = count_ff;
      else if (reg_rd && reg_addr == count_control_addr)
         nxt_rdata = control_ff;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         count_ff    <= 8'h00;
         preload_ff  <= 8'h00;
         control_ff  <= count_control_rst;
         flag_ff     <= 1'b0;
         tone_ff     <= 1'b0;
         pin_prev_ff <= 1'b0;
         psc_ff      <= 8'h00;
         rdata_ff    <= 8'h00;
         pw_ff       <= pw_idle;
      end else begin
         count_ff    <= nxt_count;
         preload_ff  <= nxt_preload;
         control_ff  <= nxt_control;
         flag_ff     <= nxt_flag;
         tone_ff     <= nxt_tone;
         pin_prev_ff <= nxt_pin_prev;
         psc_ff      <= nxt_psc;
         rdata_ff    <= nxt_rdata;
         pw_ff       <= nxt_pw;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign reg_rdata             = rdata_ff;
   assign overflow_request_flag = flag_ff;
   assign irq_request           = flag_ff && overflow_irq_enable;
   assign wake_up               = overflow;
   assign tone_output           = tone_ff;
endmodule : event_timer_pulse_counter

// file: hw/count_timer_pkg.sv
// constants for the 8-bit timer/event counter block
// assumes an 8-bit data-memory style register port on mclk
package count_timer_pkg;
   localparam logic [7:0] count_register_addr = 8'h0d;
   localparam logic [7:0] count_control_addr  = 8'h0e;
   localparam logic [7:0] count_control_rst   = 8'h08;
   localparam int         psc_lo_pos          = 0;
   localparam int         psc_hi_pos          = 2;
   localparam int         edge_select_pos     = 3;
   localparam int         count_on_pos        = 4;
   localparam int         mode_lo_pos         = 6;
   localparam int         mode_hi_pos         = 7;
   localparam logic [7:0] count_control_wmask = 8'hdf;
   localparam logic [7:0] count_full          = 8'hff;
   localparam logic [1:0] mode_unused         = 2'h0;
   localparam logic [1:0] mode_event          = 2'h1;
   localparam logic [1:0] mode_timer          = 2'h2;
   localparam logic [1:0] mode_pulse          = 2'h3;
   typedef enum logic [1:0] {pw_idle, pw_armed, pw_counting, pw_done} pw_state_t;
endpackage : count_timer_pkg

// file: hw/pin_sync.sv
// two-flop synchroniser for the external count input
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module pin_sync (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic pin_in,
   output logic      pin_sync_out
);
   logic meta_ff;
   logic nxt_meta;
   logic sync_ff;
   logic nxt_sync;

   always_comb begin
      nxt_meta = pin_in;
      nxt_sync = meta_ff;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   assign pin_sync_out = sync_ff;
endmodule : pin_sync

// file: tb/pin_source.sv
// signal source model for the external count pin
// assumes pin changes land off the mclk edge, like a real async source
`timescale 1ns/1ps
module pin_source (
   input  wire logic mclk,
   output logic      count_pin
);
   initial count_pin = 1'b0;
   // a level is held, so the edge polarity shows between changes
   task automatic drive(input logic v, input int hold);
      @(posedge mclk);
      #1 count_pin = v;
      repeat (hold) @(posedge mclk);
   endtask : drive
endmodule : pin_source

// file: tb/count_timer_asserts.sv
// port checker for event_timer_pulse_counter
// assumes one mclk domain with synchronous active-high reset
`timescale 1ns/1ps
module count_timer_asserts (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       overflow_irq_enable,
   input wire logic       overflow_flag_clear,
   input wire logic       overflow_request_flag,
   input wire logic       irq_request,
   input wire logic       wake_up,
   input wire logic       tone_output
);
   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_irq_gate: assert property (
      irq_request == (overflow_request_flag && overflow_irq_enable)) else $error("irq gate");
   a_wake_flag: assert property (
      wake_up |=> overflow_request_flag) else $error("wake without flag");
   a_tone_flip: assert property (
      wake_up |=> tone_output != $past(tone_output)) else $error("tone not toggled");
   a_flag_sticky: assert property (
      overflow_request_flag && !overflow_flag_clear |=> overflow_request_flag) else $error("flag lost");
   a_flag_clear: assert property (
      overflow_flag_clear && !wake_up |=> !overflow_request_flag) else $error("flag not cleared");
   a_flag_cause: assert property (
      $rose(overflow_request_flag) |-> $past(wake_up)) else $error("flag without overflow");
   a_rd_idle: assert property (
      !reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
   a_ctl_spare: assert property (
      reg_rd && reg_addr == 8'h0e |=> !reg_rdata[5]) else $error("spare bit set");
endmodule : count_timer_asserts
bind event_timer_pulse_counter count_timer_asserts chk (.mclk(mclk), .reset(reset),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .overflow_irq_enable(overflow_irq_enable), .overflow_flag_clear(overflow_flag_clear),
   .overflow_request_flag(overflow_request_flag), .irq_request(irq_request),
   .wake_up(wake_up), .tone_output(tone_output));

// file: tb/tb.sv
// self-checking bench for event_timer_pulse_counter
// assumes pin_source on count_pin and the bound port checker
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
   import count_timer_pkg::*;
   typedef struct {logic [7:0] a; logic [7:0] w; logic we; logic [7:0] e;} row_t;
   logic       mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, count_pin;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, m;
   logic       rtc_tick = 1'b0, opt_src = 1'b0, opt_osc = 1'b0, irq_en = 1'b0;
   logic       flag_clr = 1'b0, flag, irq, wake, tone;
   int         num_errors = 0, check_count = 0, c;
   row_t       rows [5] = '{'{8'h0e, 8'h27, 1'b1, 8'h07}, '{8'h0e, 8'hc8, 1'b1, 8'hc8},
      '{8'h0d, 8'h5a, 1'b1, 8'h5a}, '{8'h0c, 8'h00, 1'b0, 8'h00}, '{8'h0e, 8'h40, 1'b1, 8'h40}};
   always #2 mclk = ~mclk;
   pin_source src (.mclk(mclk), .count_pin(count_pin));
   event_timer_pulse_counter uut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .count_pin(count_pin), .rtc_tick(rtc_tick), .opt_rtc_source(opt_src),
      .opt_rc_rtc_osc(opt_osc), .overflow_irq_enable(irq_en), .overflow_flag_clear(flag_clr),
      .overflow_request_flag(flag), .irq_request(irq), .wake_up(wake), .tone_output(tone));
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge mclk);
      #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, w};
      @(posedge mclk);
      #1 reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge mclk);
      #1 {reg_rd, reg_addr} = {1'b1, a};
      @(posedge mclk);
      #1 reg_rd = 1'b0;
      v = reg_rdata;
   endtask : rd
   // bounded wait; a run-out shows as a wrong count
   task automatic wait_wake(output int n);
      n = 0;
      do begin
         @(posedge mclk);
         #1 n++;
      end while (wake !== 1'b1 && n < 2000);
   endtask : wait_wake
   task automatic summarize;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      #100000 num_errors++;
      summarize();
   end
   // ------------------------------
   // stimulus
   // ------------------------------
   initial begin
      repeat (16) @(posedge mclk);
      #1 reset = 1'b0;
      rd(8'h0e, d); `CHK(d, count_control_rst)
      rd(8'h0d, d); `CHK(d, 8'h00)
      foreach (rows[i]) begin
         if (rows[i].we) wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d); `CHK(d, rows[i].e)
      end
      wr(8'h0d, 8'hfe);
      irq_en = 1'b1;
      for (int n = 0; n < 8; n++) begin
         wr(8'h0e, 8'h90 | n[7:0]);
         wait_wake(c); wait_wake(c); `CHK(c, 4 << n)
         rd(8'h0e, d); `CHK(d, 8'h90 | n[7:0])
      end
      `CHK(flag, 1'b1)
      `CHK(irq, 1'b1)
      irq_en = 1'b0; #1 `CHK(irq, 1'b0)
      wr(8'h0e, 8'h80);
      flag_clr = 1'b1; @(posedge mclk); #1 flag_clr = 1'b0; `CHK(flag, 1'b0)
      {opt_src, opt_osc} = 2'b10; wr(8'h0e, 8'h90);
      wait_wake(c); wait_wake(c); `CHK(c, 4)
      opt_osc = 1'b1; wait_wake(c); wait_wake(c); `CHK(c, 2000)
      {opt_src, opt_osc} = 2'b00; wait_wake(c);
      {reg_rd, reg_addr} = {1'b1, 8'h0d}; c = 0;
      repeat (40) begin @(posedge mclk); #1 if (wake === 1'b1) c++; end
      reg_rd = 1'b0; `CHK(c, 0)
      for (int e = 0; e < 2; e++) begin
         wr(8'h0e, 8'h40 | 8'(e << 3)); wr(8'h0d, 8'h10); wr(8'h0e, 8'h50 | 8'(e << 3));
         src.drive(1'b1, 8); rd(8'h0d, d); `CHK(d, 8'h11 - 8'(e))
         src.drive(1'b0, 8); rd(8'h0d, d); `CHK(d, 8'h11)
      end
      wr(8'h0e, 8'hc0); wr(8'h0d, 8'h00); src.drive(1'b1, 8); wr(8'h0e, 8'hd0);
      src.drive(1'b1, 20); rd(8'h0d, d); `CHK(d, 8'h00)
      src.drive(1'b0, 8); src.drive(1'b1, 40); src.drive(1'b0, 8);
      rd(8'h0d, m); `CHK(m inside {[8'h13:8'h16]}, 1'b1)
      rd(8'h0e, d); `CHK(d, 8'hc0)
      src.drive(1'b1, 20); src.drive(1'b0, 8); rd(8'h0d, d); `CHK(d, m)
      wr(8'h0d, 8'h00); wr(8'h0e, 8'hd0); src.drive(1'b1, 20); src.drive(1'b0, 8);
      rd(8'h0d, d); `CHK(d inside {[8'h09:8'h0b]}, 1'b1)
      summarize();
   end
endmodule : tb
